// ==== design/adc_port_pkg.sv ====
// constants, modes and states shared by the result output port
package adc_port_pkg;

	// ------------------------------------------------------------
	// result and interface select
	// ------------------------------------------------------------
	localparam int          RESULT_BITS   = 18;         // bits per conversion result
	localparam logic [1:0]  MODE_PAR18    = 2'h0;       // 18-bit parallel bus
	localparam logic [1:0]  MODE_PAR16    = 2'h1;       // 16-bit parallel bus, two words
	localparam logic [1:0]  MODE_PAR8     = 2'h2;       // 8-bit parallel bus, three bytes
	localparam logic [1:0]  MODE_SERIAL   = 2'h3;       // serial link on the upper data pins
	localparam int          SIGN_POS      = 17;         // bit flipped for twos complement coding

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 8;          // 125 MHz system clock
	localparam int          CONV_TIME_NS  = 1400;       // conversion phase length
	localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CONV_CNT_W    = 9;          // width of the conversion counter
	localparam int          FAST_BITS     = 12;         // read-during: bits sent at the fast period
	localparam logic [4:0]  HALF_FAST     = 5'h02;      // read-during: fast half period, cycles
	localparam logic [4:0]  HALF_SLOW     = 5'h04;      // read-during: slow half period, cycles
	localparam logic [4:0]  HALF_BASE     = 5'h02;      // read-after: half period at divider 0
	localparam logic [4:0]  LAST_BIT      = 5'h11;      // index of the 18th bit
	localparam logic [4:0]  ALL_BITS      = 5'h12;      // bit count once all 18 are out

	// ------------------------------------------------------------
	// buffering
	// ------------------------------------------------------------
	localparam int          FIFO_DEPTH    = 8;          // results held between core and port

	// ------------------------------------------------------------
	// master serial clock generator, gray along idle-low-high
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW  = 2'b01,
		ST_HIGH = 2'b11
	} sclk_state_t;

endpackage

// ==== design/adc_result_output_port.sv ====
// result output port: conversion timing, parallel bus and serial link
`timescale 1ns/1ps
// Overview of operation
// - modes 0/1/2 give 18/16/8-bit parallel bus
// - cs and read low: every result shown continuously
// - continuous read drives bus, released only in reset
// - slave parallel read after or during next conversion
// - 18-bit mode always straight binary
// - two word selects fetch two words or three bytes
// - mode 3 selects serial link on data pins
// - serial result is 18 bits, msb first
// - serial bit changes on the falling clock edge, valid on the rising
// - configuration port only usable in serial mode
// - internal clock source: generate clock and frame signal
// - clock and frame outputs invertible by inputs
// - read-during master: previous result, two clock periods
// - read-after master: busy held until 18 bits out
// - divider select sets read-after clock period
// - external clock used only while chip select low
// - slave serial read after or during conversion
// - external clock may idle high or low
// - outputs released when chip select or read high
// - slave read-during: overrun pulse if a started read is unfinished
// - falling start edge converts, never restarted
module adc_result_output_port
	import adc_port_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// conversion control pins
	input  wire logic                   conversion_start_n,
	output logic                        busy,
	// converter core, same clock
	input  wire logic [RESULT_BITS-1:0] sample_result,
	output logic                        sample_ready,
	// interface control pins
	input  wire logic                   cs_n,
	input  wire logic                   rd_n,
	input  wire logic [1:0]             interface_mode,
	input  wire logic                   word_select_lo,
	input  wire logic                   word_select_hi,
	input  wire logic                   output_binary,
	// serial configuration pins
	input  wire logic                   clock_source_external,
	input  wire logic                   clock_invert,
	input  wire logic                   frame_invert,
	input  wire logic                   read_during_conversion,
	input  wire logic [1:0]             clock_divider_sel,
	// parallel data bus
	output logic [RESULT_BITS-1:0]      data_out,
	output logic                        data_oe,
	// serial link
	output logic                        serial_data_out,
	output logic                        serial_data_oe,
	input  wire logic                   serial_clock_pin_in,
	output logic                        serial_clock_pin_out,
	output logic                        serial_clock_pin_oe,
	output logic                        frame_valid,
	output logic                        frame_valid_oe,
	output logic                        read_overrun,
	output logic                        config_port_enable
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int PIN_W = 16;

	logic [PIN_W-1:0] pin_raw;              // all asynchronous pins
	logic [PIN_W-1:0] pin_meta_reg;         // first stage, read only by second
	logic [PIN_W-1:0] pin_sync_reg;         // second stage, safe to use

	assign pin_raw = {conversion_start_n, cs_n, rd_n, interface_mode, word_select_lo, word_select_hi,
		output_binary, clock_source_external, clock_invert, frame_invert, read_during_conversion,
		clock_divider_sel, serial_clock_pin_in, 1'b0};

	// two flops per pin
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_reg <= {2'h3, 14'h0};
			pin_sync_reg <= {2'h3, 14'h0};
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	logic       start_n_s;                  // synced conversion start, low active
	logic       cs_n_s;                     // synced chip select, low active
	logic       rd_n_s;                     // synced read enable, low active
	logic [1:0] mode_s;                     // synced interface select
	logic       ws_lo_s;                    // synced low word select
	logic       ws_hi_s;                    // synced high word select
	logic       binary_s;                   // synced output coding
	logic       ext_s;                      // synced clock source
	logic       sinv_s;                     // synced clock invert
	logic       finv_s;                     // synced frame invert
	logic       rdc_s;                      // synced read-during select
	logic [1:0] div_s;                      // synced divider select
	logic       sclk_s;                     // synced external serial clock

	assign start_n_s = pin_sync_reg[15];
	assign cs_n_s    = pin_sync_reg[14];
	assign rd_n_s    = pin_sync_reg[13];
	assign mode_s    = pin_sync_reg[12:11];
	assign ws_lo_s   = pin_sync_reg[10];
	assign ws_hi_s   = pin_sync_reg[9];
	assign binary_s  = pin_sync_reg[8];
	assign ext_s     = pin_sync_reg[7];
	assign sinv_s    = pin_sync_reg[6];
	assign finv_s    = pin_sync_reg[5];
	assign rdc_s     = pin_sync_reg[4];
	assign div_s     = pin_sync_reg[3:2];
	assign sclk_s    = pin_sync_reg[1];

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	logic selected;                         // chip select and read both low
	logic serial_mode;                      // link in use
	logic master_mode;                      // device makes the serial clock
	logic master_after;                     // master, read after conversion
	logic master_during;                    // master, read during conversion
	logic slave_mode;                       // host makes the serial clock

	assign selected      = ~cs_n_s & ~rd_n_s;
	assign serial_mode   = (mode_s == MODE_SERIAL);
	assign master_mode   = serial_mode & ~ext_s;
	assign master_after  = master_mode & ~rdc_s;
	assign master_during = master_mode & rdc_s;
	assign slave_mode    = serial_mode & ext_s;
	assign config_port_enable = serial_mode;

	// twos complement flips the sign bit, except on the full-width bus
	function automatic logic [RESULT_BITS-1:0] code_word(input logic [RESULT_BITS-1:0] w,
		input logic [1:0] m, input logic bin);
		logic [RESULT_BITS-1:0] r;
		r = w;
		if ((m != MODE_PAR18) && !bin) begin
			r[SIGN_POS] = ~w[SIGN_POS];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// conversion timing
	// ------------------------------------------------------------
	logic                  start_d_reg;     // last synced start level
	logic                  start_fall;      // falling edge of start
	logic                  conv_active_reg; // conversion phase running
	logic [CONV_CNT_W-1:0] conv_cnt_reg;    // cycles left in the phase
	logic                  conv_done;       // last cycle of the phase
	logic                  conv_go;         // accepted start
	logic                  push_d_reg;      // result on its way to the buffer output
	logic                  fifo_in_ready;   // room for another result
	logic                  fifo_out_valid;  // result waiting for the port
	logic [RESULT_BITS-1:0] fifo_out_data;  // oldest waiting result
	logic                  fifo_pop;        // port takes the waiting result
	sclk_state_t           st_reg;          // master clock generator state

	assign start_fall = start_d_reg & ~start_n_s;
	assign conv_done  = conv_active_reg & (conv_cnt_reg == '0);
	// a start while busy or with the buffer full is ignored
	assign conv_go    = start_fall & ~busy & fifo_in_ready;
	assign sample_ready = fifo_in_ready;

	// busy covers the phase and, read-after master, the whole transfer
	assign busy = conv_active_reg
		| (master_after & (push_d_reg | fifo_out_valid | (st_reg != ST_IDLE)));

	// start edge detector
	always_ff @(posedge clk) begin
		if (srst) begin
			start_d_reg <= 1'b1;
		end else begin
			start_d_reg <= start_n_s;
		end
	end

	// a result still crossing the buffer keeps busy up, no gap before the transfer
	always_ff @(posedge clk) begin
		if (srst) begin
			push_d_reg <= 1'b0;
		end else begin
			push_d_reg <= conv_done;
		end
	end

	// conversion phase counter, runs to the end once started
	always_ff @(posedge clk) begin
		if (srst) begin
			conv_active_reg <= 1'b0;
			conv_cnt_reg    <= '0;
		end else if (conv_go) begin
			conv_active_reg <= 1'b1;
			conv_cnt_reg    <= CONV_CNT_W'(CONV_CYCLES - 1);
		end else if (conv_done) begin
			conv_active_reg <= 1'b0;
		end else if (conv_active_reg) begin
			conv_cnt_reg    <= conv_cnt_reg - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// result buffer
	// ------------------------------------------------------------
	result_fifo #(
		.WIDTH (RESULT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (conv_done),
		.in_ready  (fifo_in_ready),
		.in_data   (sample_result),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// the master generator stalls the buffer while it shifts
	assign fifo_pop = fifo_out_valid & (st_reg == ST_IDLE);

	logic [RESULT_BITS-1:0] result_reg;     // latest result handed to the port

	// newest result, kept as the previous one for read-during transfers
	always_ff @(posedge clk) begin
		if (srst) begin
			result_reg <= '0;
		end else if (fifo_pop) begin
			result_reg <= fifo_out_data;
		end
	end

	// ------------------------------------------------------------
	// parallel bus
	// ------------------------------------------------------------
	logic [RESULT_BITS-1:0] coded;          // result in the chosen coding

	assign coded = code_word(result_reg, mode_s, binary_s);

	// word and byte steering, refreshed every cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			data_out <= '0;
		end else begin
			case (mode_s)
				MODE_PAR18: data_out <= coded;
				MODE_PAR16: begin
					if (!ws_lo_s) begin
						data_out <= {2'h0, coded[17:2]};
					end else begin
						data_out <= {2'h0, coded[1:0], 14'h0};
					end
				end
				MODE_PAR8: begin
					case ({ws_hi_s, ws_lo_s})
						2'b00:   data_out <= {10'h0, coded[17:10]};
						2'b01:   data_out <= {10'h0, coded[9:2]};
						default: data_out <= {10'h0, coded[1:0], 6'h0};
					endcase
				end
				default: data_out <= '0;
			endcase
		end
	end

	// bus driven whenever selected in a parallel mode, released in reset
	assign data_oe = ~srst & ~serial_mode & selected;

	// ------------------------------------------------------------
	// serial shifter, shared by master and slave
	// ------------------------------------------------------------
	logic [RESULT_BITS-1:0] shift_reg;      // bits still to send, msb at top
	logic [4:0]             bit_cnt_reg;    // bits already sent
	logic [4:0]             hp_cnt_reg;     // cycles left in this half period
	logic [4:0]             half;           // half period for the current bit
	logic                   m_start;        // master transfer begins
	logic                   half_end;       // last cycle of a half period
	logic                   g_d_reg;        // last gated external clock level
	logic                   g_now;          // external clock in shifting sense
	logic                   s_edge;         // shifting edge of the external clock

	// read-during: later bits slower; read-after: divider sets the period
	always_comb begin
		if (rdc_s) begin
			half = (bit_cnt_reg < 5'(FAST_BITS)) ? HALF_FAST : HALF_SLOW;
		end else begin
			half = HALF_BASE << div_s;
		end
	end

	// read-during sends the previous result at the start of a conversion
	assign m_start  = (master_during & conv_go) | (master_after & fifo_pop);
	assign half_end = (hp_cnt_reg == '0);

	// master clock generator: low half, high half, then next bit
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg     <= ST_IDLE;
			hp_cnt_reg <= '0;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (m_start) begin
						st_reg     <= ST_LOW;
						hp_cnt_reg <= half - 1'b1;
					end
				end
				ST_LOW: begin
					if (half_end) begin
						st_reg     <= ST_HIGH;
						hp_cnt_reg <= half - 1'b1;
					end else begin
						hp_cnt_reg <= hp_cnt_reg - 1'b1;
					end
				end
				ST_HIGH: begin
					if (half_end) begin
						st_reg     <= (bit_cnt_reg == LAST_BIT) ? ST_IDLE : ST_LOW;
						hp_cnt_reg <= half - 1'b1;
					end else begin
						hp_cnt_reg <= hp_cnt_reg - 1'b1;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// external clock is ignored unless selected, either idle level works
	assign g_now  = sclk_s ^ sinv_s;
	assign s_edge = slave_mode & selected & g_d_reg & ~g_now;

	// external clock edge detector, follows only while chip select low
	always_ff @(posedge clk) begin
		if (srst) begin
			g_d_reg <= 1'b0;
		end else if (~cs_n_s) begin
			g_d_reg <= g_now;
		end
	end

	// shift register: load, then one bit per clock period
	always_ff @(posedge clk) begin
		if (srst) begin
			shift_reg   <= '0;
			bit_cnt_reg <= '0;
		end else if (m_start) begin
			shift_reg   <= master_during ? code_word(result_reg, mode_s, binary_s)
				: code_word(fifo_out_data, mode_s, binary_s);
			bit_cnt_reg <= '0;
		end else if (slave_mode & fifo_pop) begin
			shift_reg   <= code_word(fifo_out_data, mode_s, binary_s);
			bit_cnt_reg <= '0;
		end else if (((st_reg == ST_HIGH) & half_end) | (s_edge & (bit_cnt_reg != ALL_BITS))) begin
			shift_reg   <= {shift_reg[RESULT_BITS-2:0], 1'b0};
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
		end
	end

	// overrun: a read-during transfer left unfinished at conversion end
	always_ff @(posedge clk) begin
		if (srst) begin
			read_overrun <= 1'b0;
		end else begin
			read_overrun <= slave_mode & conv_done & (bit_cnt_reg != '0)
				& (bit_cnt_reg != ALL_BITS);
		end
	end

	// ------------------------------------------------------------
	// serial pins
	// ------------------------------------------------------------
	assign serial_data_out      = shift_reg[RESULT_BITS-1];
	assign serial_data_oe       = ~srst & serial_mode & selected;
	assign serial_clock_pin_out = (st_reg == ST_HIGH) ^ sinv_s;
	assign serial_clock_pin_oe  = ~srst & master_mode & selected;
	assign frame_valid          = (st_reg != ST_IDLE) ^ finv_s;
	assign frame_valid_oe       = ~srst & master_mode & selected;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_accept;
		conv_go;
	endsequence

	sequence s_phase;
		busy [*8];
	endsequence

	property p_conv_busy;
		s_accept |=> s_phase;
	endproperty
	a_conv_busy: assert property (p_conv_busy) else $error("busy not held after start");

	property p_no_restart;
		conv_active_reg && !conv_done |=> conv_cnt_reg == $past(conv_cnt_reg) - 1'b1;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("conversion counter disturbed");

	property p_bus_release;
		(cs_n_s || rd_n_s) |-> !data_oe && !serial_data_oe;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("outputs driven while deselected");

	property p_bus_driven;
		selected && (mode_s != MODE_SERIAL) |-> data_oe;
	endproperty
	a_bus_driven: assert property (p_bus_driven) else $error("bus released in continuous read");

	property p_full_binary;
		(mode_s == MODE_PAR18) && $stable(mode_s) && $stable(result_reg) |=> data_out == $past(result_reg);
	endproperty
	a_full_binary: assert property (p_full_binary) else $error("18-bit bus not straight binary");

	property p_msb_first;
		m_start && master_after |=> serial_data_out == ($past(fifo_out_data[RESULT_BITS-1]) == $past(binary_s));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("serial transfer not msb first");

	property p_bit_stable;
		(st_reg == ST_LOW) && !m_start |=> $stable(serial_data_out);
	endproperty
	a_bit_stable: assert property (p_bit_stable) else $error("serial bit changed mid period");

	property p_busy_transfer;
		master_after && (st_reg != ST_IDLE) |-> busy;
	endproperty
	a_busy_transfer: assert property (p_busy_transfer) else $error("busy dropped before bits out");

	property p_overrun_pulse;
		read_overrun |=> !read_overrun;
	endproperty
	a_overrun_pulse: assert property (p_overrun_pulse) else $error("overrun longer than one cycle");

	property p_gate;
		cs_n_s |=> $stable(bit_cnt_reg) || $past(m_start) || ($past(st_reg) != ST_IDLE) || $past(fifo_pop);
	endproperty
	a_gate: assert property (p_gate) else $error("external clock used while deselected");

endmodule

// ==== design/result_fifo.sv ====
// small fifo with registered read data between the converter core and the port
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];          // storage array
	logic [PTR_W-1:0] wr_ptr_reg;           // next slot to write
	logic [PTR_W-1:0] rd_ptr_reg;           // next slot to read
	logic [PTR_W:0]   count_reg;            // words held in the array
	logic             push;                 // word accepted
	logic             pull;                 // word moved to the output register

	assign in_ready = (count_reg != DEPTH[PTR_W:0]);
	assign push     = in_valid & in_ready;
	assign pull     = (count_reg != '0) & (~out_valid | out_ready);

	// write into the array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pull) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			case ({push, pull})
				2'b10:   count_reg <= count_reg + 1'b1;
				2'b01:   count_reg <= count_reg - 1'b1;
				default: count_reg <= count_reg;
			endcase
		end
	end

	// output register, read data always come from a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pull) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr_reg];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule

// ==== verification/adc_result_output_port_test.sv ====
// self-checking bench for the result output port
`timescale 1ns/1ps
module adc_result_output_port_test;
	import adc_port_pkg::*;
	`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t value", $time); end end
	logic        clk, srst, conversion_start_n, cs_n, rd_n, word_select_lo, word_select_hi, output_binary, go;
	logic        clock_source_external, clock_invert, frame_invert, read_during_conversion;
	logic        busy, data_oe, serial_data_out, serial_data_oe, sclk_host, sclk_out, sclk_oe, frame_valid;
	logic        config_port_enable, read_overrun;
	logic [1:0]  interface_mode, clock_divider_sel;
	logic [17:0] sample_result, r, word, data_out, h, q[$];
	int          mismatches, comparisons, cycles, n, e;
	// ----------------------------------------
	// design and host
	// ----------------------------------------
	adc_result_output_port i_adc_result_output_port (.clk, .srst, .conversion_start_n, .busy, .sample_result,
		.sample_ready(), .cs_n, .rd_n, .interface_mode, .word_select_lo, .word_select_hi, .output_binary,
		.clock_source_external, .clock_invert, .frame_invert, .read_during_conversion, .clock_divider_sel,
		.data_out, .data_oe, .serial_data_out, .serial_data_oe, .serial_clock_pin_in(sclk_host),
		.serial_clock_pin_out(sclk_out), .serial_clock_pin_oe(sclk_oe), .frame_valid, .frame_valid_oe(),
		.read_overrun, .config_port_enable);
	serial_host_model i_serial_host_model (.clk, .go, .sclk_gen((sclk_out ^ clock_invert) & sclk_oe),
		.sdo(serial_data_oe ? serial_data_out : ~serial_data_out), .sclk_host, .word);
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	// counts, verdict, end
	task complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// next random sample
	function automatic logic [17:0] lfsr(input logic [17:0] s);
		return {s[16:0], s[17] ^ s[10]};
	endfunction
	// one conversion; n ends as the busy length
	task conv();
		r = lfsr(r);
		q.push_back(r);
		@(posedge clk);
		sample_result <= r;
		conversion_start_n <= 1'b0;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin @(posedge clk); n++; end
		conversion_start_n <= 1'b1;
		n = 0;
		while (busy === 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
			if (n == 60) h = data_out; // bus read in the first half of the phase
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{conversion_start_n, cs_n, rd_n, srst} = 4'hf;
		{word_select_lo, word_select_hi, output_binary, clock_source_external, clock_invert, go} = '0;
		{frame_invert, read_during_conversion, interface_mode, clock_divider_sel, sample_result} = '0;
		{r, cycles, mismatches, comparisons} = {18'h44, 96'h0};
		repeat (12) @(posedge clk);
		`chk(data_oe | serial_data_oe | sclk_oe, 1'b0)
		{srst, cs_n, rd_n} <= 3'h0;
		conv();
		`chk(n > 170 && n < 180, 1'b1)
		repeat (6) @(posedge clk);
		`chk(data_out, q[$])
		`chk(data_oe, 1'b1)
		for (int k = 0; k < 5; k++) begin
			interface_mode <= (k < 2) ? MODE_PAR16 : MODE_PAR8;
			word_select_lo <= (k == 1 || k == 3);
			word_select_hi <= (k == 4);
			output_binary <= (k != 0);
			e = (k == 0) ? (r ^ 18'h20000) >> 2 : (k == 1) ? r[1:0] << 14 : (k == 2) ? r[17:10] : (k == 3) ? r[9:2] : r[1:0] << 6;
			repeat (6) @(posedge clk);
			`chk(data_out[15:0], e[15:0])
		end
		{interface_mode, output_binary} <= {MODE_PAR18, 1'b0};
		conv();
		`chk(h, q[$-1])
		repeat (6) @(posedge clk);
		`chk(data_out, q[$])
		{rd_n, output_binary} <= 2'h3;
		repeat (4) @(posedge clk);
		`chk(data_oe, 1'b0)
		{interface_mode, clock_source_external, rd_n} <= {MODE_SERIAL, 2'h2};
		conv();
		repeat (6) @(posedge clk);
		go <= 1'b1; // host clocks only once busy is low
		repeat (320) @(posedge clk);
		go <= 1'b0;
		`chk(word, r)
		`chk({config_port_enable, sclk_oe}, 2'h2)
		conv();
		`chk(read_overrun, 1'b0)
		go <= 1'b1;
		conv();
		`chk(read_overrun, 1'b1)
		repeat (120) @(posedge clk);
		go <= 1'b0;
		clock_source_external <= 1'b0;
		for (int d = 0; d < 2; d++) begin
			{clock_divider_sel, frame_invert, clock_invert} <= {d[1:0], d[0], d[0]};
			conv();
			`chk(n >= 175 + 36 * (2 << d) && n < 200 + 36 * (2 << d), 1'b1)
			repeat (4) @(posedge clk);
			`chk(word, r)
			`chk(frame_valid, d[0])
		end
		read_during_conversion <= 1'b1;
		conv();
		repeat (4) @(posedge clk);
		`chk(word, q[$-1])
		complete_run();
	end
endmodule

// ==== verification/serial_host_model.sv ====
// host model on the far side of the serial link
`timescale 1ns/1ps
module serial_host_model (
	// clock and control
	input  wire logic        clk,
	input  wire logic        go,
	// serial link
	input  wire logic        sclk_gen,
	input  wire logic        sdo,
	output logic             sclk_host,
	output logic [17:0]      word
);
	// each bit taken on a rising edge, of the device's clock or of the host's own
	always @(posedge sclk_gen or posedge sclk_host) word <= {word[16:0], sdo};
	// host clocks the link: 18 pulses, idle low, only after a go request
	initial begin
		sclk_host = 1'b0;
		forever begin
			@(posedge go);
			repeat (18) begin
				repeat (8) @(posedge clk);
				sclk_host <= 1'b1; // bit still stands on the rise
				repeat (8) @(posedge clk);
				sclk_host <= 1'b0; // fall asks for the next bit
			end
		end
	end
endmodule
